// file: common/wake_timer_pkg.sv
// Register map, field positions and timing counts of the stop mode wakeup timer.
package wake_timer_pkg;
  localparam logic [7:0] ADDR_PORT_A      = 8'h00;
  localparam logic [7:0] ADDR_KBD_STATUS  = 8'h1a;
  localparam logic [7:0] ADDR_KBD_ENABLE  = 8'h1b;
  localparam logic [7:0] ADDR_OPTION_B    = 8'h1e;
  localparam logic [7:0] ADDR_OPTION_A    = 8'h1f;

  localparam int BIT_WAKE_LATCH   = 6;
  localparam int BIT_PENDING_FLAG = 3;
  localparam int BIT_ACKNOWLEDGE  = 2;
  localparam int BIT_INT_MASK     = 1;
  localparam int BIT_WAKE_INT_EN  = 6;
  localparam int BIT_OSC_KEEP     = 1;
  localparam int BIT_RESET_PIN    = 0;
  localparam int BIT_PERIOD_SEL   = 7;
  localparam int BIT_LV_TRIP      = 3;
  localparam int BIT_SHORT_REC    = 2;
  localparam int BIT_WDOG_DIS     = 0;

  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  localparam int WAKE_SHORT_CYCLES  = 512;
  localparam int WAKE_LONG_CYCLES   = 16384;
  localparam int REC_SHORT_CYCLES   = 32;
  localparam int REC_LONG_CYCLES    = 4096;
  localparam int WDOG_SHORT_CYCLES  = 8176;
  localparam int WDOG_LONG_CYCLES   = 262128;

  localparam int WAKE_W = 14;
  localparam int REC_W  = 12;
  localparam int WDOG_W = 18;

  typedef enum logic [1:0] {
    REC_IDLE,
    REC_COUNT,
    REC_DONE
  } rec_state_t;
endpackage : wake_timer_pkg

// file: verilog/stop_mode_wakeup_timer.sv
// Stop mode wakeup timer with keyboard interrupt merge and write-once option registers.
// What this block does
// - Port A bit reads wakeup latch, read-only.
// - Status register bits 7 to 4 read zero.
// - Pending flag set by keyboard or wakeup request.
// - Acknowledge write clears both requests; reads zero.
// - Mask bit suppresses keyboard and wakeup interrupts.
// - Wakeup enable gates latching of wakeup request.
// - Keep-oscillator bit selects doubled bus clock source.
// - Stop recovery: 32 or 4096 quad clocks.
// - Option registers take one write per reset.
// - Option registers decode at 0x1e and 0x1f.
// - Option register A holds the documented bit order.
// - Outside stop, period select sets watchdog timeout.
// - Reset pin function cleared by power-on only.
// - Counter overflow sets latch when enabled.
// - Wakeup counter restarts from zero at stop entry.
// - Wakeup counting runs only in stop mode.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module stop_mode_wakeup_timer
  import wake_timer_pkg::*;
#(
  parameter logic [WAKE_W-1:0] WAKE_LONG = WAKE_W'(WAKE_LONG_CYCLES),
  parameter logic [WDOG_W-1:0] WDOG_LONG = WDOG_W'(WDOG_LONG_CYCLES)
) (
  input  wire logic       mclk,         // Bus clock times four, 25 MHz.
  input  wire logic       rst_n,        // System reset, async, active low.
  input  wire logic       por_n,        // Power-on reset, async, active low.
  input  wire logic       clk_en,       // Freezes all state while low.
  input  wire logic [7:0] addr,         // Register address.
  input  wire logic [7:0] wdata,        // Register write data.
  input  wire logic       wr,           // Write strobe.
  input  wire logic       rd,           // Read strobe.
  output logic      [7:0] rdata,        // Read data, valid the cycle after rd.
  input  wire logic       stop_mode,    // High while the device is in stop mode.
  input  wire logic       kbd_event,    // Keyboard request pulse from the pin logic.
  input  wire logic       rc_osc,       // Dedicated wakeup oscillator, asynchronous.
  input  wire logic       bus_x2_tick,  // One-cycle tick of the doubled bus clock.
  input  wire logic       wdog_clear,   // Watchdog service pulse.
  output logic            kbd_irq,      // Shared keyboard interrupt request.
  output logic            osc_run_stop, // Keep bus clock source alive in stop.
  output logic            stop_exit,    // Pulse when stop recovery delay has elapsed.
  output logic            wdog_reset,   // Pulse on watchdog timeout.
  output logic            reset_pin_en, // Reset pin function enable.
  output logic            stop_instr_en // Stop instruction enable.
);

  logic any_rst_n;
  assign any_rst_n = rst_n & por_n;

  // Register bus decode.
  logic wr_stat, wr_enab, wr_opt_b, wr_opt_a;
  assign wr_stat  = wr && (addr == ADDR_KBD_STATUS);
  assign wr_enab  = wr && (addr == ADDR_KBD_ENABLE);
  assign wr_opt_b = wr && (addr == ADDR_OPTION_B);
  assign wr_opt_a = wr && (addr == ADDR_OPTION_A);

  // Control and request state.
  logic       wake_latch_r, wake_latch_nxt;
  logic       kbd_req_r, kbd_req_nxt;
  logic       int_mask_r, int_mask_nxt;
  logic       wake_int_en_r, wake_int_en_nxt;
  logic [7:0] opt_a_r, opt_a_nxt;
  logic [7:0] opt_b_r, opt_b_nxt;
  logic       lv_trip_r, lv_trip_nxt;
  logic       reset_pin_r, reset_pin_nxt;
  logic       opt_a_done_r, opt_a_done_nxt;
  logic       opt_b_done_r, opt_b_done_nxt;
  logic       wake_ovf;
  logic       ack;

  // The port A write has no effect here: bit 6 is a latch, not a port bit.
  assign ack = wr_stat && wdata[BIT_ACKNOWLEDGE];

  always_comb begin
    wake_latch_nxt  = wake_latch_r;
    kbd_req_nxt     = kbd_req_r;
    int_mask_nxt    = int_mask_r;
    wake_int_en_nxt = wake_int_en_r;
    opt_a_nxt       = opt_a_r;
    opt_b_nxt       = opt_b_r;
    lv_trip_nxt     = lv_trip_r;
    reset_pin_nxt   = reset_pin_r;
    opt_a_done_nxt  = opt_a_done_r;
    opt_b_done_nxt  = opt_b_done_r;
    // A request arriving with the acknowledge is kept: set wins over clear.
    if (ack) begin
      wake_latch_nxt = 1'b0;
      kbd_req_nxt    = 1'b0;
    end
    if (wake_ovf && wake_int_en_r) begin
      wake_latch_nxt = 1'b1;
    end
    if (kbd_event) begin
      kbd_req_nxt = 1'b1;
    end
    if (wr_stat) begin
      int_mask_nxt = wdata[BIT_INT_MASK];
    end
    if (wr_enab) begin
      wake_int_en_nxt = wdata[BIT_WAKE_INT_EN];
    end
    if (wr_opt_a && !opt_a_done_r) begin
      opt_a_nxt      = wdata;
      lv_trip_nxt    = wdata[BIT_LV_TRIP];
      opt_a_done_nxt = 1'b1;
    end
    if (wr_opt_b && !opt_b_done_r) begin
      opt_b_nxt      = wdata;
      reset_pin_nxt  = wdata[BIT_RESET_PIN];
      opt_b_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      wake_latch_r  <= 1'b0;
      kbd_req_r     <= 1'b0;
      int_mask_r    <= 1'b0;
      wake_int_en_r <= 1'b0;
      opt_a_r       <= OPTION_RESET;
      opt_b_r       <= OPTION_RESET;
      opt_a_done_r  <= 1'b0;
      opt_b_done_r  <= 1'b0;
    end else if (clk_en) begin
      wake_latch_r  <= wake_latch_nxt;
      kbd_req_r     <= kbd_req_nxt;
      int_mask_r    <= int_mask_nxt;
      wake_int_en_r <= wake_int_en_nxt;
      opt_a_r       <= opt_a_nxt;
      opt_b_r       <= opt_b_nxt;
      opt_a_done_r  <= opt_a_done_nxt;
      opt_b_done_r  <= opt_b_done_nxt;
    end
  end

  // Trip select and reset pin function survive system resets.
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      lv_trip_r   <= 1'b0;
      reset_pin_r <= 1'b0;
    end else if (clk_en) begin
      lv_trip_r   <= lv_trip_nxt;
      reset_pin_r <= reset_pin_nxt;
    end
  end

  // Readable option bytes with the power-on-only bits merged in.
  logic [7:0] opt_a_view, opt_b_view;
  always_comb begin
    opt_a_view              = opt_a_r;
    opt_a_view[BIT_LV_TRIP] = lv_trip_r;
    opt_b_view                = opt_b_r;
    opt_b_view[BIT_RESET_PIN] = reset_pin_r;
  end

  logic pending;
  assign pending       = kbd_req_r | wake_latch_r;
  assign kbd_irq       = pending & ~int_mask_r;
  assign osc_run_stop  = opt_b_r[BIT_OSC_KEEP];
  assign reset_pin_en  = reset_pin_r;
  assign stop_instr_en = opt_a_r[BIT_WDOG_DIS + 1];

  // Read data, registered one cycle after the strobe.
  logic [7:0] rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = ZERO_BYTE;
    if (rd) begin
      unique case (addr)
        ADDR_PORT_A:     rdata_nxt[BIT_WAKE_LATCH] = wake_latch_r;
        ADDR_KBD_STATUS: begin
          // Upper nibble and the acknowledge bit always read zero.
          rdata_nxt[BIT_PENDING_FLAG] = pending;
          rdata_nxt[BIT_INT_MASK]     = int_mask_r;
        end
        ADDR_KBD_ENABLE: rdata_nxt[BIT_WAKE_INT_EN] = wake_int_en_r;
        ADDR_OPTION_B:   rdata_nxt = opt_b_view;
        ADDR_OPTION_A:   rdata_nxt = opt_a_view;
        default:         rdata_nxt = ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rdata_r <= ZERO_BYTE;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  // Oscillator synchroniser; a rising edge counts once the second and third stages agree.
  logic osc_s1_r, osc_s2_r, osc_s3_r, osc_lvl_r, osc_lvl_nxt;
  logic osc_tick;
  always_comb begin
    osc_lvl_nxt = (osc_s2_r == osc_s3_r) ? osc_s3_r : osc_lvl_r;
  end
  assign osc_tick = osc_lvl_nxt & ~osc_lvl_r;

  always_ff @(posedge mclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      osc_lvl_r <= 1'b0;
    end else if (clk_en) begin
      osc_s1_r  <= rc_osc;
      osc_s2_r  <= osc_s1_r;
      osc_s3_r  <= osc_s2_r;
      osc_lvl_r <= osc_lvl_nxt;
    end
  end

  // Wakeup counter, held at zero outside stop so every stop entry starts fresh.
  logic [WAKE_W-1:0] wake_cnt_r, wake_cnt_nxt;
  logic [WAKE_W-1:0] wake_last;
  logic              wake_tick;
  assign wake_tick = osc_run_stop ? bus_x2_tick : osc_tick;
  assign wake_last = opt_a_r[BIT_PERIOD_SEL] ?
                     WAKE_W'(WAKE_SHORT_CYCLES - 1) :
                     WAKE_LONG - WAKE_W'(1);
  assign wake_ovf  = stop_mode && wake_tick && (wake_cnt_r == wake_last);

  always_comb begin
    wake_cnt_nxt = wake_cnt_r;
    if (!stop_mode) begin
      wake_cnt_nxt = '0;
    end else if (wake_tick) begin
      wake_cnt_nxt = (wake_cnt_r == wake_last) ? '0 : wake_cnt_r + WAKE_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      wake_cnt_r <= '0;
    end else if (clk_en) begin
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // Stop recovery: an unmasked request in stop starts the exit delay.
  rec_state_t       rec_st_r, rec_st_nxt;
  logic [REC_W-1:0] rec_cnt_r, rec_cnt_nxt;
  logic [REC_W-1:0] rec_last;
  assign rec_last = opt_a_r[BIT_SHORT_REC] ?
                    REC_W'(REC_SHORT_CYCLES - 1) :
                    REC_W'(REC_LONG_CYCLES - 1);

  always_comb begin
    rec_st_nxt  = rec_st_r;
    rec_cnt_nxt = rec_cnt_r;
    unique case (rec_st_r)
      REC_IDLE: begin
        rec_cnt_nxt = '0;
        if (stop_mode && kbd_irq) begin
          rec_st_nxt = REC_COUNT;
        end
      end
      REC_COUNT: begin
        if (rec_cnt_r == rec_last) begin
          rec_st_nxt = REC_DONE;
        end else begin
          rec_cnt_nxt = rec_cnt_r + REC_W'(1);
        end
      end
      REC_DONE: begin
        // Wait for the core to leave stop so one exit gives one pulse.
        if (!stop_mode) begin
          rec_st_nxt = REC_IDLE;
        end
      end
    endcase
  end
  assign stop_exit = (rec_st_r == REC_COUNT) && (rec_cnt_r == rec_last);

  always_ff @(posedge mclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rec_st_r  <= REC_IDLE;
      rec_cnt_r <= '0;
    end else if (clk_en) begin
      rec_st_r  <= rec_st_nxt;
      rec_cnt_r <= rec_cnt_nxt;
    end
  end

  // Watchdog: the same period bit picks its timeout while out of stop.
  logic [WDOG_W-1:0] wdog_cnt_r, wdog_cnt_nxt;
  logic [WDOG_W-1:0] wdog_last;
  logic              wdog_hit;
  assign wdog_last = opt_a_r[BIT_PERIOD_SEL] ?
                     WDOG_W'(WDOG_SHORT_CYCLES - 1) :
                     WDOG_LONG - WDOG_W'(1);
  assign wdog_hit  = !stop_mode && !opt_a_r[BIT_WDOG_DIS] && (wdog_cnt_r == wdog_last);
  assign wdog_reset = wdog_hit;

  always_comb begin
    wdog_cnt_nxt = wdog_cnt_r;
    // Stop clears the count, so the core need not service it around stop.
    if (stop_mode || wdog_clear || opt_a_r[BIT_WDOG_DIS] || wdog_hit) begin
      wdog_cnt_nxt = '0;
    end else begin
      wdog_cnt_nxt = wdog_cnt_r + WDOG_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      wdog_cnt_r <= '0;
    end else if (clk_en) begin
      wdog_cnt_r <= wdog_cnt_nxt;
    end
  end

endmodule : stop_mode_wakeup_timer

// file: sim/wake_timer_properties.sv
// Port-level properties of the stop mode wakeup timer.
`timescale 1ns/1ps
module wake_timer_properties
  import wake_timer_pkg::*;
#(
  parameter logic [WAKE_W-1:0] WAKE_LONG = WAKE_W'(WAKE_LONG_CYCLES),
  parameter logic [WDOG_W-1:0] WDOG_LONG = WDOG_W'(WDOG_LONG_CYCLES)
) (
  input wire logic       mclk,         // Clock.
  input wire logic       rst_n,        // System reset.
  input wire logic       por_n,        // Power-on reset.
  input wire logic       clk_en,       // Clock enable.
  input wire logic [7:0] addr,         // Address.
  input wire logic [7:0] wdata,        // Write data.
  input wire logic       wr,           // Write strobe.
  input wire logic       rd,           // Read strobe.
  input wire logic [7:0] rdata,        // Read data.
  input wire logic       stop_mode,    // Stop mode.
  input wire logic       kbd_event,    // Keyboard pulse.
  input wire logic       kbd_irq,      // Interrupt.
  input wire logic       osc_run_stop, // Keep oscillator.
  input wire logic       stop_exit,    // Recovery done.
  input wire logic       wdog_reset,   // Watchdog timeout.
  input wire logic       reset_pin_en  // Reset pin enable.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !por_n);

  chk_rdata_idle: assert property (($past(clk_en) && !$past(rd)) |-> rdata == ZERO_BYTE)
    else $error("read data not zero outside a read");
  chk_status_zero: assert property (
    ($past(rd && clk_en) && $past(addr) == ADDR_KBD_STATUS)
    |-> (rdata[7:4] == 4'h0 && !rdata[BIT_ACKNOWLEDGE]))
    else $error("status unused or acknowledge bit read as one");
  chk_flag_irq: assert property (
    ($past(rd && clk_en && kbd_irq) && $past(addr) == ADDR_KBD_STATUS)
    |-> rdata[BIT_PENDING_FLAG])
    else $error("pending flag clear while interrupt raised");
  chk_ack_clears: assert property (
    (wr && clk_en && addr == ADDR_KBD_STATUS
    && wdata[BIT_ACKNOWLEDGE] && !stop_mode && !kbd_event) |=> !kbd_irq)
    else $error("acknowledge did not drop the interrupt");
  chk_mask_blocks: assert property (
    (wr && clk_en && addr == ADDR_KBD_STATUS
    && wdata[BIT_INT_MASK]) |=> !kbd_irq)
    else $error("masked interrupt still raised");
  chk_exit_once: assert property (stop_exit |=> !stop_exit [*4])
    else $error("recovery pulse repeated");
  chk_exit_cause: assert property (stop_exit |-> $past(stop_mode && kbd_irq, 30))
    else $error("recovery pulse too early or without a request");
  chk_wdog_quiet: assert property (($past(stop_mode) && stop_mode) |-> !wdog_reset)
    else $error("watchdog timeout in stop mode");
  chk_wdog_pulse: assert property (wdog_reset |=> !wdog_reset)
    else $error("watchdog timeout did not restart");
  chk_option_hold: assert property (
    !$past(wr && clk_en && addr == ADDR_OPTION_B)
    |-> ($stable(osc_run_stop) && $stable(reset_pin_en)))
    else $error("option outputs changed without a write");
endmodule : wake_timer_properties

bind stop_mode_wakeup_timer wake_timer_properties #(
  .WAKE_LONG(WAKE_LONG), .WDOG_LONG(WDOG_LONG)) wake_timer_properties_inst (
  .mclk(mclk), .rst_n(rst_n), .por_n(por_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .stop_mode(stop_mode), .kbd_event(kbd_event),
  .kbd_irq(kbd_irq), .osc_run_stop(osc_run_stop), .stop_exit(stop_exit),
  .wdog_reset(wdog_reset), .reset_pin_en(reset_pin_en));

// file: sim/testbench.sv
// Self-checking bench for the stop mode wakeup timer.
`timescale 1ns/1ps
module testbench;
  import wake_timer_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       por_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       stop_mode = 1'b0;
  logic       kbd_event = 1'b0;
  logic       rc_osc = 1'b0;
  logic       rc_on = 1'b0;
  logic       rc_div = 1'b0;
  logic       clk_en = 1'b1;
  logic       bus_x2_tick = 1'b0;
  logic       tick_on = 1'b0;
  logic [7:0] rdata;
  logic       kbd_irq, osc_run_stop, stop_exit, wdog_reset, reset_pin_en, stop_instr_en;
  int         num_errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  int         n;

  // Shortened long counts keep the run brief; expectations below use them.
  stop_mode_wakeup_timer #(.WAKE_LONG(14'h0040), .WDOG_LONG(18'h000c8))
    stop_mode_wakeup_timer_inst (
    .mclk(mclk), .rst_n(rst_n), .por_n(por_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .stop_mode(stop_mode), .kbd_event(kbd_event),
    .rc_osc(rc_osc), .bus_x2_tick(bus_x2_tick), .wdog_clear(1'b0), .kbd_irq(kbd_irq),
    .osc_run_stop(osc_run_stop), .stop_exit(stop_exit), .wdog_reset(wdog_reset),
    .reset_pin_en(reset_pin_en), .stop_instr_en(stop_instr_en));

  always #20 mclk = ~mclk;

  // The oscillator only runs inside stop, as the real one does.
  // It flips every other edge: a level that flips every cycle never lets the
  // second and third synchroniser stages agree, so no edge would ever count.
  always @(posedge mclk) begin
    bus_x2_tick <= tick_on;
    if (rc_on) begin
      rc_div <= ~rc_div;
      if (rc_div) begin
        rc_osc <= ~rc_osc;
      end
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic in_range(input string name, input int v, input int lo, input int hi);
    check(name, 16'(v), (v >= lo && v <= hi) ? 16'(v) : 16'(lo));
  endtask : in_range

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check($sformatf("register %h", a), {8'h00, rdata}, {8'h00, exp});
  endtask : rd_reg

  task automatic count_until(input int which, output int cnt);
    cnt = 0;
    do begin
      @(negedge mclk);
      cnt++;
    end while ((which == 0 ? kbd_irq : (which == 1 ? stop_exit : wdog_reset)) !== 1'b1
               && cnt < 20000);
  endtask : count_until

  task automatic do_reset(input bit por);
    @(posedge mclk);
    rst_n <= 1'b0;
    por_n <= ~por;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask : do_reset

  task automatic set_stop(input logic s, input logic tick, input logic rc);
    @(posedge mclk);
    stop_mode <= s;
    tick_on <= tick;
    rc_on <= rc;
  endtask : set_stop

  task automatic t_reset_values;
    rd_reg(ADDR_OPTION_A, OPTION_RESET);
    rd_reg(ADDR_OPTION_B, OPTION_RESET);
    rd_reg(ADDR_KBD_ENABLE, ZERO_BYTE);
    rd_reg(ADDR_PORT_A, ZERO_BYTE);
    rd_reg(8'h55, ZERO_BYTE);
    wr_reg(ADDR_KBD_STATUS, 8'hf0);
    rd_reg(ADDR_KBD_STATUS, ZERO_BYTE);
  endtask : t_reset_values

  task automatic t_option_once;
    wr_reg(ADDR_OPTION_A, 8'h8e);
    wr_reg(ADDR_OPTION_B, 8'h03);
    wr_reg(ADDR_OPTION_A, 8'h71);
    wr_reg(ADDR_OPTION_B, 8'h00);
    rd_reg(ADDR_OPTION_A, 8'h8e);
    rd_reg(ADDR_OPTION_B, 8'h03);
    check("outputs", {13'h0000, stop_instr_en, osc_run_stop, reset_pin_en}, 16'h0007);
  endtask : t_option_once

  task automatic t_wake_short;
    wr_reg(ADDR_KBD_ENABLE, 8'h40);
    rd_reg(ADDR_KBD_ENABLE, 8'h40);
    set_stop(1'b0, 1'b1, 1'b0);
    repeat (600) @(negedge mclk);
    check("irq in run", {15'h0000, kbd_irq}, 16'h0000);
    set_stop(1'b1, 1'b1, 1'b0);
    repeat (300) @(posedge mclk);
    set_stop(1'b0, 1'b1, 1'b0);
    set_stop(1'b1, 1'b1, 1'b0);
    count_until(0, n);
    in_range("wake short", n, 511, 516);
    count_until(1, n);
    in_range("recovery short", n, 31, 34);
    rd_reg(ADDR_PORT_A, 8'h40);
    rd_reg(ADDR_KBD_STATUS, 8'h08);
    wr_reg(ADDR_PORT_A, 8'h00);
    rd_reg(ADDR_PORT_A, 8'h40);
    set_stop(1'b0, 1'b0, 1'b0);
    wr_reg(ADDR_KBD_STATUS, 8'h02);
    rd_reg(ADDR_KBD_STATUS, 8'h0a);
    check("masked irq", {15'h0000, kbd_irq}, 16'h0000);
    rd_reg(ADDR_PORT_A, 8'h40);
    wr_reg(ADDR_KBD_STATUS, 8'h04);
    rd_reg(ADDR_PORT_A, ZERO_BYTE);
    rd_reg(ADDR_KBD_STATUS, ZERO_BYTE);
  endtask : t_wake_short

  task automatic t_reset_kinds;
    do_reset(1'b0);
    rd_reg(ADDR_OPTION_A, 8'h08);
    rd_reg(ADDR_OPTION_B, 8'h01);
    rd_reg(ADDR_KBD_ENABLE, ZERO_BYTE);
    do_reset(1'b1);
    rd_reg(ADDR_OPTION_A, OPTION_RESET);
    rd_reg(ADDR_OPTION_B, OPTION_RESET);
  endtask : t_reset_kinds

  task automatic t_wake_long;
    wr_reg(ADDR_OPTION_B, 8'h00);
    set_stop(1'b1, 1'b0, 1'b1);
    repeat (300) @(negedge mclk);
    check("irq disabled", {15'h0000, kbd_irq}, 16'h0000);
    // A keyboard event while the clock enable is low must leave no trace.
    @(posedge mclk);
    clk_en <= 1'b0;
    kbd_event <= 1'b1;
    @(posedge mclk);
    clk_en <= 1'b1;
    kbd_event <= 1'b0;
    @(negedge mclk);
    check("frozen event", {15'h0000, kbd_irq}, 16'h0000);
    set_stop(1'b0, 1'b0, 1'b0);
    wr_reg(ADDR_KBD_ENABLE, 8'h40);
    set_stop(1'b1, 1'b0, 1'b1);
    count_until(0, n);
    in_range("wake long", n, 255, 266);
    count_until(1, n);
    in_range("recovery long", n, 4095, 4098);
    set_stop(1'b0, 1'b0, 1'b0);
    wr_reg(ADDR_KBD_STATUS, 8'h04);
  endtask : t_wake_long

  task automatic t_kbd_and_wdog;
    @(posedge mclk);
    kbd_event <= 1'b1;
    @(posedge mclk);
    kbd_event <= 1'b0;
    @(negedge mclk);
    check("keyboard irq", {15'h0000, kbd_irq}, 16'h0001);
    rd_reg(ADDR_KBD_STATUS, 8'h08);
    wr_reg(ADDR_KBD_STATUS, 8'h04);
    rd_reg(ADDR_KBD_STATUS, ZERO_BYTE);
    count_until(2, n);
    count_until(2, n);
    in_range("watchdog long", n, 200, 200);
    do_reset(1'b0);
    wr_reg(ADDR_OPTION_A, 8'h80);
    count_until(2, n);
    count_until(2, n);
    in_range("watchdog short", n, 8176, 8176);
  endtask : t_kbd_and_wdog

  initial begin
    do_reset(1'b1);
    t_reset_values();
    t_option_once();
    t_wake_short();
    t_reset_kinds();
    t_wake_long();
    t_kbd_and_wdog();
    end_of_test();
  end
endmodule : testbench
